// ==== src/rail_fault_protection_supervisor.sv ====
// Purpose: fault supervisor gating the phase drivers of one rail
// Assumes: comparator flags are asynchronous; PWM and command are on clock
// Notes:   latches clear on reset or while enable is low, lockout only once the supply is no longer low
`timescale 1ns/1ns
`include "rail_fault_defs.svh"

module rail_fault_protection_supervisor
   import rail_fault_pkg::*;
#(
   parameter int PHASES            = 4,
   parameter int CNT_W             = 16,
   parameter int TRIGGER_DELAY_CYC = 1000,
   parameter int ACTION_DELAY_CYC  = 500,
   parameter int SETTLE_CYC        = 200,
   parameter int TARGET_W          = 8,
   parameter logic [TARGET_W-1:0] TARGET_0V9_CODE = 8'h40
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Pin and comparator inputs
   input  wire logic                enable,
   input  wire logic                porDone,
   input  wire logic                avgAboveThreshold,
   input  wire logic                peakAboveThreshold,
   input  wire logic                senseAboveFixedLevel,
   input  wire logic                senseAboveRefMargin,
   input  wire logic                senseBelowZero,
   input  wire logic                senseBelowRefMargin,
   input  wire logic                supplyMonitorLow,
   input  wire logic                driverSupplyMonitorLow,
   input  wire logic                secondaryPhase1SenseNegHigh,
   input  wire logic                switchingCycle,
   // On-clock control inputs
   input  wire logic [TARGET_W-1:0] voltageTargetCode,
   input  wire logic [PHASES-1:0]   pwmHigh,
   input  wire logic [PHASES-1:0]   pwmLow,
   input  wire logic                serialVoltageCommandValid,
   input  wire logic                serialVoltageCommandSecondary,
   // Gate enables
   output logic [PHASES-1:0]        highGateEn,
   output logic [PHASES-1:0]        lowGateEn,
   // Status and indicators
   output logic                     overcurrentIndicator_n,
   output logic                     averagedOvercurrentTrip,
   output logic                     peakOvercurrentTrip,
   output logic                     overvoltageLatch,
   output logic                     negativeVoltageGuard,
   output logic                     undervoltageLatch,
   output logic                     supplyLockout,
   output logic                     siblingSoftShutdownReq,
   output logic                     secondaryRailDisabled,
   output logic                     commandAccept,
   output logic                     commandReject
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: first stage read only by the second

   logic [`IN_COUNT-1:0] asyncIn;
   logic [`IN_COUNT-1:0] syncMeta;
   logic [`IN_COUNT-1:0] syncIn;

   assign asyncIn = {switchingCycle, secondaryPhase1SenseNegHigh,
                     driverSupplyMonitorLow, supplyMonitorLow,
                     senseBelowRefMargin, senseBelowZero,
                     senseAboveRefMargin, senseAboveFixedLevel,
                     peakAboveThreshold, avgAboveThreshold,
                     porDone, enable};

   genvar gs;
   generate
      for (gs = 0; gs < `IN_COUNT; gs++) begin : g_sync
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               syncMeta[gs] <= 1'b0;
               syncIn[gs]   <= 1'b0;
            end else begin
               syncMeta[gs] <= asyncIn[gs];
               syncIn[gs]   <= syncMeta[gs];
            end
         end
      end
   endgenerate

   wire enabled   = syncIn[`IN_ENABLE];
   wire porReady  = syncIn[`IN_POR_DONE];
   wire avgOver   = syncIn[`IN_AVG_OVER];
   wire peakOver  = syncIn[`IN_PEAK_OVER];
   wire belowZero = syncIn[`IN_BELOW_ZERO];

   ////////////////////////////////////////////////////////////////////////
   // Persistence filters: over-voltage, under-voltage, supply-low

   localparam int FILTERS = 3;
   localparam int FILT_CYC [FILTERS] = '{`OV_PERSIST_CYC,
                                         `UV_PERSIST_CYC,
                                         `LOCKOUT_PERSIST_CYC};

   wire targetBelow0v9 = voltageTargetCode < TARGET_0V9_CODE;
   // Fixed level at low targets, reference margin otherwise
   wire ovSelect = targetBelow0v9 ? syncIn[`IN_OV_FIXED]
                                  : syncIn[`IN_OV_REF];
   wire ovCond     = porReady && enabled && ovSelect;
   wire uvCond     = porReady && enabled && syncIn[`IN_UV_BELOW];
   wire supplyLow  = syncIn[`IN_VCC_LOW] || syncIn[`IN_DRV_LOW];

   logic [FILTERS-1:0] filtIn;
   logic [FILTERS-1:0] filtHit;
   logic [CNT_W-1:0]   filtCount [FILTERS];

   assign filtIn = {supplyLow, uvCond, ovCond};

   genvar gf;
   generate
      for (gf = 0; gf < FILTERS; gf++) begin : g_filt
         localparam logic [CNT_W-1:0] LAST = CNT_W'(FILT_CYC[gf] - 1);
         // Hit from the cycle that completes an unbroken run for as long as the input stays high
         assign filtHit[gf] = filtIn[gf] && (filtCount[gf] == LAST);
         always_ff @(posedge clock) begin
            if (!rst_n || !filtIn[gf]) begin
               filtCount[gf] <= '0;
            end else if (filtCount[gf] != LAST) begin
               filtCount[gf] <= filtCount[gf] + 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Protection latches

   wire next_overvoltageLatch  = filtHit[0] || (overvoltageLatch && enabled);
   wire next_undervoltageLatch = filtHit[1] || (undervoltageLatch && enabled);
   // Lockout does not wait for enable, a sagging supply matters always
   wire next_supplyLockout     = filtHit[2] || (supplyLockout && enabled);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         overvoltageLatch  <= 1'b0;
         undervoltageLatch <= 1'b0;
         supplyLockout     <= 1'b0;
      end else begin
         overvoltageLatch  <= next_overvoltageLatch;
         undervoltageLatch <= next_undervoltageLatch;
         supplyLockout     <= next_supplyLockout;
      end
   end

   // Guard follows the zero comparator, so it releases by itself
   wire next_negativeVoltageGuard = overvoltageLatch && belowZero;

   ////////////////////////////////////////////////////////////////////////
   // Over-current detection and action sequence

   localparam logic [CNT_W-1:0] TRIG_LAST   = CNT_W'(TRIGGER_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] ACTION_LAST = CNT_W'(ACTION_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

   logic [CNT_W-1:0] avgCount;
   logic [CNT_W-1:0] ocCount;
   logic             cyclePrev;
   oc_state_t        ocState;
   oc_state_t        next_ocState;

   wire cycleStart = syncIn[`IN_SWITCH_CYCLE] && !cyclePrev;
   wire avgTripNow  = avgOver && (avgCount == TRIG_LAST);
   wire peakTripNow = cycleStart && peakOver;
   wire anyTrip     = (avgTripNow || peakTripNow) && enabled;
   wire stillOver   = avgOver || peakOver;
   wire ocCountDone = (ocState == OC_DELAY)  ? (ocCount == ACTION_LAST)
                    : (ocState == OC_SETTLE) ? (ocCount == SETTLE_LAST)
                    : 1'b0;

   always_ff @(posedge clock) begin
      if (!rst_n || !avgOver) begin
         avgCount <= '0;
      end else if (avgCount != TRIG_LAST) begin
         avgCount <= avgCount + 1'b1;
      end
   end

   always_comb begin
      next_ocState = ocState;
      case (ocState)
         OC_IDLE: begin
            if (anyTrip) begin
               next_ocState = OC_DELAY;
            end
         end
         OC_DELAY: begin
            if (ocCountDone) begin
               next_ocState = OC_SETTLE;
            end
         end
         OC_SETTLE: begin
            if (ocCountDone) begin
               next_ocState = stillOver ? OC_SHUT : OC_IDLE;
            end
         end
         OC_SHUT: begin
            next_ocState = OC_SHUT;
         end
         default: begin
            next_ocState = OC_IDLE;
         end
      endcase
      if (!enabled) begin
         next_ocState = OC_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ocState   <= OC_IDLE;
         ocCount   <= '0;
         cyclePrev <= 1'b0;
      end else begin
         ocState   <= next_ocState;
         ocCount   <= (next_ocState != ocState) ? '0 : ocCount + 1'b1;
         cyclePrev <= syncIn[`IN_SWITCH_CYCLE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate steering, priority: lockout, under-voltage, over-current,
   // disabled, over-voltage clamp, normal PWM

   wire allOff = next_supplyLockout || next_undervoltageLatch
              || next_ocState == OC_SHUT || !enabled;
   wire clampLow = next_overvoltageLatch && !next_negativeVoltageGuard;

   logic [PHASES-1:0] next_highGateEn;
   logic [PHASES-1:0] next_lowGateEn;

   assign next_highGateEn = (allOff || next_overvoltageLatch) ? '0
                          : pwmHigh;
   assign next_lowGateEn  = allOff   ? '0
                          : clampLow ? '1
                          : next_overvoltageLatch ? '0
                          : pwmLow;

   ////////////////////////////////////////////////////////////////////////
   // Output registers

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         highGateEn              <= '0;
         lowGateEn               <= '0;
         overcurrentIndicator_n  <= 1'b1;
         averagedOvercurrentTrip <= 1'b0;
         peakOvercurrentTrip     <= 1'b0;
         negativeVoltageGuard    <= 1'b0;
         siblingSoftShutdownReq  <= 1'b0;
         secondaryRailDisabled   <= 1'b0;
         commandAccept           <= 1'b0;
         commandReject           <= 1'b0;
      end else begin
         highGateEn              <= next_highGateEn;
         lowGateEn               <= next_lowGateEn;
         overcurrentIndicator_n  <= (next_ocState == OC_IDLE);
         averagedOvercurrentTrip <= avgTripNow;
         peakOvercurrentTrip     <= peakTripNow;
         negativeVoltageGuard    <= next_negativeVoltageGuard;
         siblingSoftShutdownReq  <= next_overvoltageLatch
                                 || next_undervoltageLatch;
         secondaryRailDisabled   <= syncIn[`IN_SEC_NEG_HIGH];
         commandAccept           <= serialVoltageCommandValid
                                 && !(serialVoltageCommandSecondary
                                      && secondaryRailDisabled);
         commandReject           <= serialVoltageCommandValid
                                 && serialVoltageCommandSecondary
                                 && secondaryRailDisabled;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ov_persist_time: assert property (
      $rose(overvoltageLatch) |-> $past(filtCount[0]) == CNT_W'(99))
      else $error("over-voltage latched without 1us persistence");

   a_uv_persist_time: assert property (
      $rose(undervoltageLatch) |-> $past(filtCount[1]) == CNT_W'(299))
      else $error("under-voltage latched without 3us persistence");

   a_lockout_persist: assert property (
      $rose(supplyLockout) |-> $past(filtCount[2]) == CNT_W'(299))
      else $error("lockout entered without 3us persistence");

   a_ov_needs_por: assert property (
      $rose(overvoltageLatch) |-> $past(porReady))
      else $error("over-voltage evaluated before power-on reset done");

   a_ov_gate_clamp: assert property (
      overvoltageLatch && !negativeVoltageGuard && !supplyLockout
      && !undervoltageLatch && ocState != OC_SHUT && enabled
      |-> lowGateEn == '1 && highGateEn == '0)
      else $error("over-voltage clamp not applied to gates");

   a_nv_only_latched: assert property (
      negativeVoltageGuard |-> $past(overvoltageLatch))
      else $error("negative guard active without over-voltage latch");

   a_nv_gates_off: assert property (
      negativeVoltageGuard |-> lowGateEn == '0 && highGateEn == '0)
      else $error("negative guard left a gate on");

   a_uv_gates_off: assert property (
      undervoltageLatch || supplyLockout
      |-> highGateEn == '0 && lowGateEn == '0)
      else $error("gate on during under-voltage or lockout");

   a_oc_indicator: assert property (
      ocState == OC_IDLE && anyTrip |=> !overcurrentIndicator_n
      && ocState == OC_DELAY)
      else $error("trip did not raise indicator and delay");

   a_oc_shut_off: assert property (
      ocState == OC_SHUT |-> highGateEn == '0 && lowGateEn == '0)
      else $error("gates on after over-current shutdown");

   a_sibling_req: assert property (
      overvoltageLatch || undervoltageLatch |-> siblingSoftShutdownReq)
      else $error("sibling shutdown not requested");

   a_cmd_reject: assert property (
      serialVoltageCommandValid && serialVoltageCommandSecondary
      && secondaryRailDisabled |=> commandReject && !commandAccept)
      else $error("command to disabled rail not rejected");

   c_ov_then_nv: cover property (
      overvoltageLatch ##[1:1000] negativeVoltageGuard);
   c_oc_shutdown: cover property ($rose(ocState == OC_SHUT));
   c_oc_recover: cover property (
      ocState == OC_SETTLE ##1 ocState == OC_IDLE);
   c_lockout: cover property ($rose(supplyLockout));

endmodule

// ==== src/rail_fault_defs.svh ====
// Purpose: timing counts and input bit positions for the rail supervisor
// Assumes: 100 MHz clock
// Notes:   minimum times round up to whole cycles
`ifndef RAIL_FAULT_DEFS_SVH
`define RAIL_FAULT_DEFS_SVH

`define CLK_PERIOD_NS     10
`define OV_PERSIST_NS     1000
`define UV_PERSIST_NS     3000
`define LOCKOUT_PERSIST_NS 3000
`define NS_TO_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OV_PERSIST_CYC    `NS_TO_CYC(`OV_PERSIST_NS)
`define UV_PERSIST_CYC    `NS_TO_CYC(`UV_PERSIST_NS)
`define LOCKOUT_PERSIST_CYC `NS_TO_CYC(`LOCKOUT_PERSIST_NS)

// Positions in the synchronised comparator vector
`define IN_ENABLE         0
`define IN_POR_DONE       1
`define IN_AVG_OVER       2
`define IN_PEAK_OVER      3
`define IN_OV_FIXED       4
`define IN_OV_REF         5
`define IN_BELOW_ZERO     6
`define IN_UV_BELOW       7
`define IN_VCC_LOW        8
`define IN_DRV_LOW        9
`define IN_SEC_NEG_HIGH   10
`define IN_SWITCH_CYCLE   11
`define IN_COUNT          12

`endif

// ==== src/rail_fault_pkg.sv ====
// Purpose: types shared by the rail supervisor
// Assumes: nothing
// Notes:   state codes are fixed binary
package rail_fault_pkg;

   typedef enum logic [1:0] {
      OC_IDLE   = 2'b00,
      OC_DELAY  = 2'b01,
      OC_SETTLE = 2'b10,
      OC_SHUT   = 2'b11
   } oc_state_t;

endpackage

// ==== bench/phase_stage_model.sv ====
// Purpose: phase drivers and output node seen by the rail supervisor
// Assumes: gate enables are registered on the rising clock edge
// Notes:   output goes negative while every low side conducts under negSwing, or whenever forceNeg is set
`timescale 1ns/1ns

module phase_stage_model #(
   parameter int PHASES = 4
) (
   // Clock
   input  wire logic              clock,
   // Gate enables
   input  wire logic [PHASES-1:0] highGateEn,
   input  wire logic [PHASES-1:0] lowGateEn,
   // Scenario controls
   input  wire logic              negSwing,
   input  wire logic              forceNeg,
   // Output node and driver status
   output logic                   senseBelowZero,
   output logic                   shootSeen
);

   initial begin
      senseBelowZero = 1'b0;
      shootSeen = 1'b0;
   end

   // Sticky: a shorted leg cannot be undone
   always @(posedge clock) begin
      #1;
      senseBelowZero = forceNeg | (negSwing & (&lowGateEn));
      if ((highGateEn & lowGateEn) != '0) begin
         shootSeen = 1'b1;
      end
   end

endmodule

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the rail fault supervisor
// Assumes: short over-current delays; persist counts from the header
// Notes:   every scenario is its own task
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nMismatch++; \
   $display("ERROR %0t value mismatch", $time); end end

module tb;
   import rail_fault_pkg::*;
   localparam int DLY = 4;
   logic clock, rst_n, enable, porDone, avgAboveThreshold;
   logic peakAboveThreshold, senseAboveFixedLevel, senseAboveRefMargin;
   logic senseBelowZero, senseBelowRefMargin, supplyMonitorLow;
   logic driverSupplyMonitorLow, secondaryPhase1SenseNegHigh;
   logic switchingCycle, serialVoltageCommandValid;
   logic serialVoltageCommandSecondary, negSwing, forceNeg, shootSeen;
   logic [7:0] voltageTargetCode;
   logic [3:0] pwmHigh, pwmLow, highGateEn, lowGateEn;
   logic overcurrentIndicator_n, averagedOvercurrentTrip;
   logic peakOvercurrentTrip, overvoltageLatch, negativeVoltageGuard;
   logic undervoltageLatch, supplyLockout, siblingSoftShutdownReq;
   logic secondaryRailDisabled, commandAccept, commandReject;
   int   nMismatch = 0;
   int   checked = 0;

   rail_fault_protection_supervisor #(
      .TRIGGER_DELAY_CYC(DLY), .ACTION_DELAY_CYC(DLY), .SETTLE_CYC(DLY)
   ) i_dut (
      .clock, .rst_n, .enable, .porDone, .avgAboveThreshold,
      .peakAboveThreshold, .senseAboveFixedLevel, .senseAboveRefMargin,
      .senseBelowZero, .senseBelowRefMargin, .supplyMonitorLow,
      .driverSupplyMonitorLow, .secondaryPhase1SenseNegHigh,
      .switchingCycle, .voltageTargetCode, .pwmHigh, .pwmLow,
      .serialVoltageCommandValid, .serialVoltageCommandSecondary,
      .highGateEn, .lowGateEn, .overcurrentIndicator_n,
      .averagedOvercurrentTrip, .peakOvercurrentTrip, .overvoltageLatch,
      .negativeVoltageGuard, .undervoltageLatch, .supplyLockout,
      .siblingSoftShutdownReq, .secondaryRailDisabled, .commandAccept,
      .commandReject
   );

   phase_stage_model #(.PHASES(4)) i_stage (
      .clock, .highGateEn, .lowGateEn, .negSwing, .forceNeg,
      .senseBelowZero, .shootSeen
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic testDone();
      if (nMismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return overvoltageLatch;
         1: return undervoltageLatch;
         2: return supplyLockout;
         3: return !overcurrentIndicator_n;
         4: return (highGateEn | lowGateEn) == 4'h0;
         5: return lowGateEn == 4'h0;
         6: return lowGateEn == 4'hF;
         7: return overcurrentIndicator_n;
         default: return secondaryRailDisabled;
      endcase
   endfunction

   // Counts edges until the picked flag rises; a hang ends the run
   task automatic waitSig(input int s, input int lim, output int n);
      n = 0;
      while (pick(s) !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      if (pick(s) !== 1'b1) begin
         nMismatch++;
         $display("ERROR %0t wait ran out", $time);
         testDone();
      end
   endtask

   task automatic doReset();
      rst_n = 1'b0;
      {enable, porDone} = 2'b11;
      {avgAboveThreshold, peakAboveThreshold, senseAboveFixedLevel} = '0;
      {senseAboveRefMargin, senseBelowRefMargin, supplyMonitorLow} = '0;
      {driverSupplyMonitorLow, secondaryPhase1SenseNegHigh} = '0;
      {switchingCycle, serialVoltageCommandValid} = '0;
      {serialVoltageCommandSecondary, negSwing, forceNeg} = '0;
      voltageTargetCode = 8'h10;
      pwmHigh = 4'h5;
      pwmLow = 4'hA;
      tick(2);
      rst_n = 1'b1;
      tick(3);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic sOvFixed();
      int n;
      doReset();
      forceNeg = 1'b1;
      tick(10);
      `CHK(negativeVoltageGuard, 1'b0)
      `CHK(lowGateEn, pwmLow)
      forceNeg = 1'b0;
      senseAboveFixedLevel = 1'b1;
      tick(98);
      senseAboveFixedLevel = 1'b0;
      tick(5);
      `CHK(overvoltageLatch, 1'b0)
      senseAboveFixedLevel = 1'b1;
      waitSig(0, 200, n);
      `CHK(n, 102)
      `CHK(highGateEn, 4'h0)
      `CHK(lowGateEn, 4'hF)
      `CHK(siblingSoftShutdownReq, 1'b1)
      senseAboveFixedLevel = 1'b0;
      tick(20);
      `CHK(overvoltageLatch, 1'b1)
      negSwing = 1'b1;
      waitSig(5, 10, n);
      `CHK(highGateEn, 4'h0)
      waitSig(6, 10, n);
      `CHK(highGateEn, 4'h0)
      negSwing = 1'b0;
   endtask

   task automatic sOvRef();
      int n;
      doReset();
      voltageTargetCode = 8'h40;
      senseAboveFixedLevel = 1'b1;
      tick(150);
      `CHK(overvoltageLatch, 1'b0)
      voltageTargetCode = 8'h3F;
      porDone = 1'b0;
      tick(150);
      `CHK(overvoltageLatch, 1'b0)
      {porDone, senseAboveFixedLevel, senseAboveRefMargin} = 3'b101;
      tick(150);
      `CHK(overvoltageLatch, 1'b0)
      voltageTargetCode = 8'h41;
      waitSig(0, 200, n);
      // Target is on-clock: no synchroniser delay, only the 1us persistence
      `CHK(n, 100)
   endtask

   task automatic sUv();
      int n;
      doReset();
      senseBelowRefMargin = 1'b1;
      tick(290);
      `CHK(undervoltageLatch, 1'b0)
      waitSig(1, 50, n);
      `CHK(n, 12)
      `CHK(highGateEn | lowGateEn, 4'h0)
      `CHK(siblingSoftShutdownReq, 1'b1)
      senseBelowRefMargin = 1'b0;
      enable = 1'b0;
      tick(6);
      `CHK(undervoltageLatch, 1'b0)
      enable = 1'b1;
      tick(6);
      `CHK(lowGateEn, pwmLow)
   endtask

   task automatic sLockout();
      int n;
      for (int k = 0; k < 2; k++) begin
         doReset();
         supplyMonitorLow = (k == 0);
         driverSupplyMonitorLow = (k == 1);
         waitSig(2, 400, n);
         `CHK(n, 302)
         `CHK(highGateEn | lowGateEn, 4'h0)
      end
   endtask

   task automatic sOcAvg();
      int n;
      doReset();
      avgAboveThreshold = 1'b1;
      tick(2);
      avgAboveThreshold = 1'b0;
      tick(10);
      `CHK(overcurrentIndicator_n, 1'b1)
      avgAboveThreshold = 1'b1;
      waitSig(3, 20, n);
      `CHK(averagedOvercurrentTrip, 1'b1)
      `CHK(highGateEn, pwmHigh)
      waitSig(4, 20, n);
      `CHK(n, 2 * DLY)
      `CHK(overcurrentIndicator_n, 1'b0)
   endtask

   task automatic sOcPeak();
      int n;
      doReset();
      peakAboveThreshold = 1'b1;
      tick(10);
      `CHK(overcurrentIndicator_n, 1'b1)
      `CHK(peakOvercurrentTrip, 1'b0)
      switchingCycle = 1'b1;
      tick(2);
      switchingCycle = 1'b0;
      waitSig(3, 10, n);
      `CHK(peakOvercurrentTrip, 1'b1)
      peakAboveThreshold = 1'b0;
      waitSig(7, 30, n);
      `CHK(highGateEn, pwmHigh)
      `CHK(lowGateEn, pwmLow)
   endtask

   task automatic cmd(input logic sec, input logic rej);
      int n;
      {serialVoltageCommandValid, serialVoltageCommandSecondary} = {1'b1, sec};
      tick(1);
      serialVoltageCommandValid = 1'b0;
      n = 0;
      while (commandAccept !== 1'b1 && commandReject !== 1'b1 && n < 3) begin
         tick(1);
         n++;
      end
      `CHK(commandReject, rej)
      `CHK(commandAccept, !rej)
      tick(1);
      `CHK(commandAccept | commandReject, 1'b0)
   endtask

   task automatic sCmd();
      int n;
      doReset();
      cmd(1'b1, 1'b0);
      secondaryPhase1SenseNegHigh = 1'b1;
      waitSig(8, 10, n);
      `CHK(secondaryRailDisabled, 1'b1)
      cmd(1'b1, 1'b1);
      cmd(1'b0, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      doReset();
      sOvFixed();
      sOvRef();
      sUv();
      sLockout();
      sOcAvg();
      sOcPeak();
      sCmd();
      `CHK(shootSeen, 1'b0)
      testDone();
   end

endmodule
